// ### design/lccr_cfg.svh
// Offsets, reset values, field positions and timing counts of the link configuration registers.
// Assumes a 20 MHz system clock and a byte-wide register port fed by the serial control front end.
`ifndef LCCR_CFG_SVH
`define LCCR_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define LCCR_OFS_CFG1 8'h03
`define LCCR_OFS_WDOG 8'h04
`define LCCR_OFS_SBC1 8'h05

// ----------------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------------
`define LCCR_RST_CFG1 8'hF0
`define LCCR_RST_WDOG 8'hFE
`define LCCR_RST_SBC1 8'h2E
`define LCCR_WMASK_CFG1 8'h5D
`define LCCR_RD_UNMAPPED 8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LCCR_CFG1_CRC_EN 6
`define LCCR_CFG1_SYNC_FILT 4
`define LCCR_CFG1_PASS_THRU 3
`define LCCR_CFG1_AUTO_ACK 2
`define LCCR_CFG1_EDGE_SEL 0
`define LCCR_WDOG_TO_MSB 7
`define LCCR_WDOG_TO_LSB 1
`define LCCR_WDOG_DIS 0
`define LCCR_SBC1_PASS_ALL 7
`define LCCR_SBC1_HOLD_MSB 6
`define LCCR_SBC1_HOLD_LSB 4
`define LCCR_SBC1_GF_MSB 3
`define LCCR_SBC1_GF_LSB 0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LCCR_CLK_PERIOD_NS 50
`define LCCR_WDOG_UNIT_MS 2
`define LCCR_WDOG_UNIT_CYC ((`LCCR_WDOG_UNIT_MS * 1000000) / `LCCR_CLK_PERIOD_NS)
`define LCCR_HOLD_STEP_NS 50
`define LCCR_HOLD_STEP_CYC (`LCCR_HOLD_STEP_NS / `LCCR_CLK_PERIOD_NS)
`define LCCR_GF_STEP_NS 5
`define LCCR_SYNC_FILT_CYC 2

`endif

// ### design/lccr_pkg.sv
// Types shared by the link configuration register block.
// Assumes the constants of lccr_cfg.svh.
package lccr_pkg;

	// Watchdog states, Gray coded along idle, run, abort
	typedef enum logic [1:0] {
		LCCR_WD_IDLE = 2'b00,
		LCCR_WD_RUN = 2'b01,
		LCCR_WD_ABORT = 2'b11
	} lccr_wd_state_t;

	typedef logic [7:0] lccr_byte_t;

endpackage : lccr_pkg

// ### design/lccr_regs.sv
// Link configuration registers with the logic they steer: pin filters, SDA hold, forwarding, watchdog.
// Assumes a byte-wide register port from the serial control slave, and transaction strobes on clk_i.
`timescale 1ns/100ps
`include "lccr_cfg.svh"

// Notes on behaviour
// - Back-channel CRC generation follows its enable bit.
// - Sync and valid pulses under two clocks dropped.
// - Pass-through-all bit forwards every bus transaction.
// - Edge select bit picks rising or falling strobe.
// - Watchdog aborts control-channel transactions running too long.
// - Timeout field counts in two millisecond units.
// - Watchdog disable bit stops watchdog when set.
// - SDA input delayed by hold field, 50 ns steps.
// - SCL/SDA glitches rejected up to depth times 5 ns.
module lccr_regs #(
	parameter int WDOG_UNIT_CYC = `LCCR_WDOG_UNIT_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic hsync_i,
	input wire logic vsync_i,
	input wire logic data_valid_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic hsync_o,
	output logic vsync_o,
	output logic data_valid_o,
	output logic scl_filt_o,
	output logic sda_held_o,
	input wire logic xact_start_i,
	input wire logic xact_remote_i,
	input wire logic cc_busy_i,
	output logic xact_fwd_o,
	output logic auto_ack_o,
	output logic cc_abort_o,
	output logic crc_gen_en_o,
	output logic strobe_rising_o
);

	localparam int NLANE = 5;
	// SCL and SDA idle high; the lanes reset to that level so no false edge follows reset
	localparam logic [4:0] LANE_IDLE = 5'h18;
	localparam int PW = $clog2(WDOG_UNIT_CYC + 1);

	// ------------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------------
	lccr_pkg::lccr_byte_t cfg1_q, cfg1_d, wdog_q, wdog_d, sbc1_q, sbc1_d;
	lccr_pkg::lccr_byte_t rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;

	function automatic lccr_pkg::lccr_byte_t lccr_read(input logic [7:0] addr, input lccr_pkg::lccr_byte_t c1,
		input lccr_pkg::lccr_byte_t wd, input lccr_pkg::lccr_byte_t s1);
		case (addr)
			`LCCR_OFS_CFG1: lccr_read = c1;
			`LCCR_OFS_WDOG: lccr_read = wd;
			`LCCR_OFS_SBC1: lccr_read = s1;
			default: lccr_read = `LCCR_RD_UNMAPPED;
		endcase
	endfunction : lccr_read

	always_comb begin
		cfg1_d = cfg1_q;
		wdog_d = wdog_q;
		sbc1_d = sbc1_q;
		if (reg_wr_i) begin
			case (reg_addr_i)
				// Reserved positions keep their reset value
				`LCCR_OFS_CFG1: cfg1_d = (reg_wdata_i & `LCCR_WMASK_CFG1) | (`LCCR_RST_CFG1 & ~`LCCR_WMASK_CFG1);
				`LCCR_OFS_WDOG: wdog_d = reg_wdata_i;
				`LCCR_OFS_SBC1: sbc1_d = reg_wdata_i;
				default: cfg1_d = cfg1_q;
			endcase
		end
		rvalid_d = reg_rd_i;
		rdata_d = reg_rd_i ? lccr_read(reg_addr_i, cfg1_q, wdog_q, sbc1_q) : rdata_q;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg1_q <= `LCCR_RST_CFG1;
			wdog_q <= `LCCR_RST_WDOG;
			sbc1_q <= `LCCR_RST_SBC1;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			cfg1_q <= cfg1_d;
			wdog_q <= wdog_d;
			sbc1_q <= sbc1_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	wire logic [6:0] wd_timeout = wdog_q[`LCCR_WDOG_TO_MSB:`LCCR_WDOG_TO_LSB];
	wire logic wd_dis = wdog_q[`LCCR_WDOG_DIS];
	wire logic [2:0] hold_sel = sbc1_q[`LCCR_SBC1_HOLD_MSB:`LCCR_SBC1_HOLD_LSB];
	wire logic [3:0] gf_depth = sbc1_q[`LCCR_SBC1_GF_MSB:`LCCR_SBC1_GF_LSB];
	wire logic filt_en = cfg1_q[`LCCR_CFG1_SYNC_FILT];

	// ------------------------------------------------------------------------
	// Pin synchronisers and pulse filters
	// ------------------------------------------------------------------------
	// Lanes: 0 hsync, 1 vsync, 2 data valid, 3 scl, 4 sda
	logic [NLANE-1:0] pin_in, s1_q, s2_q, s3_q, st_q, st_d, out_q, out_d;
	logic [2:0] thr [NLANE];
	logic [2:0] cnt_q [NLANE];
	logic [2:0] cnt_d [NLANE];
	// Depth in whole clock periods, rounded down; a glitch of n periods may span n + 1 samples
	wire logic [2:0] gf_cyc = 3'((32'(gf_depth) * `LCCR_GF_STEP_NS) / `LCCR_CLK_PERIOD_NS);

	assign pin_in = {sda_i, scl_i, data_valid_i, vsync_i, hsync_i};

	genvar gi;
	generate
		for (gi = 0; gi < NLANE; gi++) begin : g_lane
			always_comb begin
				// Agreement already drops one-sample pulses; a pulse under two periods may still span two
				if (gi < 3) begin
					thr[gi] = filt_en ? 3'(`LCCR_SYNC_FILT_CYC + 1) : 3'd1;
				end else begin
					thr[gi] = (gf_cyc == 3'd0) ? 3'd1 : gf_cyc + 3'd2;
				end
				// A change counts once the second and third stages agree
				st_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : st_q[gi];
				cnt_d[gi] = 3'd0;
				out_d[gi] = out_q[gi];
				if (st_q[gi] != out_q[gi]) begin
					if (cnt_q[gi] + 3'd1 >= thr[gi]) begin
						out_d[gi] = st_q[gi];
					end else begin
						cnt_d[gi] = cnt_q[gi] + 3'd1;
					end
				end
			end

			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					cnt_q[gi] <= 3'd0;
				end else begin
					cnt_q[gi] <= cnt_d[gi];
				end
			end

			a_filt_thresh: assert property (@(posedge clk_i) disable iff (rst_i)
				$changed(out_q[gi]) |-> ($past(cnt_q[gi]) + 3'd1 >= $past(thr[gi])))
				else $error("Filtered lane changed before its threshold");
		end
	endgenerate

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_q <= LANE_IDLE;
			s2_q <= LANE_IDLE;
			s3_q <= LANE_IDLE;
			st_q <= LANE_IDLE;
			out_q <= LANE_IDLE;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			st_q <= st_d;
			out_q <= out_d;
		end
	end

	// ------------------------------------------------------------------------
	// SDA hold delay
	// ------------------------------------------------------------------------
	logic [6:0] hold_sr_q, hold_sr_d;
	logic sda_held_q, sda_held_d;

	always_comb begin
		hold_sr_d = {hold_sr_q[5:0], out_q[4]};
		// One tap per 50 ns step of hold
		sda_held_d = (hold_sel == 3'd0) ? out_q[4] : hold_sr_q[hold_sel - 3'd1];
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hold_sr_q <= 7'h7F;
			sda_held_q <= 1'b1;
		end else begin
			hold_sr_q <= hold_sr_d;
			sda_held_q <= sda_held_d;
		end
	end

	// ------------------------------------------------------------------------
	// Transaction forwarding
	// ------------------------------------------------------------------------
	logic fwd_q, fwd_d;

	always_comb begin
		fwd_d = xact_start_i && (sbc1_q[`LCCR_SBC1_PASS_ALL] ||
			(cfg1_q[`LCCR_CFG1_PASS_THRU] && xact_remote_i));
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fwd_q <= 1'b0;
		end else begin
			fwd_q <= fwd_d;
		end
	end

	// ------------------------------------------------------------------------
	// Control-channel watchdog
	// ------------------------------------------------------------------------
	lccr_pkg::lccr_wd_state_t wd_q, wd_d;
	logic [PW-1:0] presc_q, presc_d;
	logic [6:0] units_q, units_d;
	logic abort_q, abort_d;
	wire logic unit_tick = (presc_q == PW'(WDOG_UNIT_CYC - 1));

	always_comb begin
		wd_d = wd_q;
		presc_d = presc_q;
		units_d = units_q;
		abort_d = 1'b0;
		case (wd_q)
			lccr_pkg::LCCR_WD_IDLE: begin
				presc_d = '0;
				units_d = 7'd0;
				if (cc_busy_i && !wd_dis) begin
					wd_d = lccr_pkg::LCCR_WD_RUN;
				end
			end
			lccr_pkg::LCCR_WD_RUN: begin
				if (!cc_busy_i || wd_dis) begin
					wd_d = lccr_pkg::LCCR_WD_IDLE;
				end else if (unit_tick) begin
					presc_d = '0;
					units_d = units_q + 7'd1;
					// A zero field is never programmed; it would wrap to 128 units
					if (units_q + 7'd1 == wd_timeout) begin
						wd_d = lccr_pkg::LCCR_WD_ABORT;
						abort_d = 1'b1;
					end
				end else begin
					presc_d = presc_q + PW'(1);
				end
			end
			lccr_pkg::LCCR_WD_ABORT: begin
				if (!cc_busy_i) begin
					wd_d = lccr_pkg::LCCR_WD_IDLE;
				end
			end
			default: wd_d = lccr_pkg::LCCR_WD_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wd_q <= lccr_pkg::LCCR_WD_IDLE;
			presc_q <= '0;
			units_q <= 7'd0;
			abort_q <= 1'b0;
		end else begin
			wd_q <= wd_d;
			presc_q <= presc_d;
			units_q <= units_d;
			abort_q <= abort_d;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign reg_rdata_o = rdata_q;
	assign reg_rvalid_o = rvalid_q;
	assign hsync_o = out_q[0];
	assign vsync_o = out_q[1];
	assign data_valid_o = out_q[2];
	assign scl_filt_o = out_q[3];
	assign sda_held_o = sda_held_q;
	assign xact_fwd_o = fwd_q;
	assign auto_ack_o = cfg1_q[`LCCR_CFG1_AUTO_ACK];
	assign cc_abort_o = abort_q;
	assign crc_gen_en_o = cfg1_q[`LCCR_CFG1_CRC_EN];
	assign strobe_rising_o = cfg1_q[`LCCR_CFG1_EDGE_SEL];

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_cfg1_write;
		reg_wr_i && reg_addr_i == `LCCR_OFS_CFG1;
	endsequence

	sequence s_wdog_expire;
		wd_q == lccr_pkg::LCCR_WD_RUN && cc_busy_i && !wd_dis && unit_tick && units_q + 7'd1 == wd_timeout;
	endsequence

	a_crc_enable: assert property (s_cfg1_write |=> crc_gen_en_o == $past(reg_wdata_i[6]))
		else $error("CRC enable did not follow write");
	a_sync_two_clk: assert property (filt_en && $past(filt_en) && $changed(hsync_o) |->
		$past(st_q[0], 1) == hsync_o && $past(st_q[0], 2) == hsync_o && $past(st_q[0], 3) == hsync_o)
		else $error("Short sync pulse passed the filter");
	a_pass_all_fwd: assert property (xact_start_i && sbc1_q[7] |=> xact_fwd_o)
		else $error("Transaction not forwarded with pass-through-all");
	a_no_fwd: assert property (xact_start_i && !sbc1_q[7] && !cfg1_q[3] |=> !xact_fwd_o)
		else $error("Transaction forwarded while forwarding off");
	a_edge_select: assert property (s_cfg1_write |=> strobe_rising_o == $past(reg_wdata_i[0]))
		else $error("Strobe edge select did not follow write");
	a_wdog_abort: assert property (s_wdog_expire |=> cc_abort_o ##1 !cc_abort_o)
		else $error("Watchdog expiry did not give one abort pulse");
	a_abort_cause: assert property (cc_abort_o |-> $past(wd_q) == lccr_pkg::LCCR_WD_RUN && $past(unit_tick))
		else $error("Abort without expiry");
	a_wdog_disable: assert property (wd_dis && wd_q == lccr_pkg::LCCR_WD_RUN |=> wd_q == lccr_pkg::LCCR_WD_IDLE)
		else $error("Watchdog kept running while disabled");
	a_sda_hold: assert property (hold_sel == 3'd2 && $past(hold_sel) == 3'd2 |-> sda_held_o == $past(out_q[4], 3))
		else $error("SDA hold delay wrong");
	a_rsvd_read: assert property (reg_rd_i && reg_addr_i == `LCCR_OFS_CFG1 |=>
		reg_rvalid_o && reg_rdata_o[7] && reg_rdata_o[5] && !reg_rdata_o[1])
		else $error("Reserved bits read wrong");

endmodule : lccr_regs

// ### test/lccr_cc_model.sv
// Far-side model: starts control-channel transactions and keeps busy up for a set length.
// Assumes go_i is driven on the rising edge of clk_i; it ends a transaction early on abort.
`timescale 1ns/100ps
module lccr_cc_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire logic remote_i,
	input wire logic [7:0] len_i,
	input wire logic abort_i,
	output logic xact_start_o,
	output logic xact_remote_o,
	output logic cc_busy_o
);
	// ------------------------------------------------------------
	// Transaction sequencer
	// ------------------------------------------------------------
	logic [7:0] cnt_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			xact_start_o <= 1'b0;
			xact_remote_o <= 1'b0;
			cc_busy_o <= 1'b0;
			cnt_q <= 8'h00;
		end else begin
			xact_start_o <= go_i;
			// Remote flag only means something with start, so it toggles every clock in between
			xact_remote_o <= go_i ? remote_i : ~xact_remote_o;
			if (go_i) begin
				cc_busy_o <= 1'b1;
				cnt_q <= len_i;
			end else if (abort_i || cnt_q == 8'h00) begin
				cc_busy_o <= 1'b0;
			end else begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule : lccr_cc_model

// ### test/tb_top.sv
// Self-checking bench of the link configuration registers against an integer register model.
// Assumes the watchdog unit is shortened to 4 clocks through WDOG_UNIT_CYC.
`timescale 1ns/100ps
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic go = 1'b0;
	logic rem = 1'b0;
	logic [7:0] len = 8'h00;
	logic [4:0] pin = 5'h18;
	logic [4:0] pout;
	logic [7:0] rdata;
	logic rvalid, xs, xr, busy, fwd, aack, abort, crc, rise;
	int fails = 0;
	int comparisons = 0;
	int mreg [3];
	always #25 clk_i = ~clk_i;
	lccr_regs #(.WDOG_UNIT_CYC(4)) lccr_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
		.hsync_i(pin[0]), .vsync_i(pin[1]), .data_valid_i(pin[2]), .scl_i(pin[3]), .sda_i(pin[4]),
		.hsync_o(pout[0]), .vsync_o(pout[1]), .data_valid_o(pout[2]), .scl_filt_o(pout[3]),
		.sda_held_o(pout[4]), .xact_start_i(xs), .xact_remote_i(xr), .cc_busy_i(busy), .xact_fwd_o(fwd),
		.auto_ack_o(aack), .cc_abort_o(abort), .crc_gen_en_o(crc), .strobe_rising_o(rise));
	lccr_cc_model lccr_cc_model_inst (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .remote_i(rem), .len_i(len),
		.abort_i(abort), .xact_start_o(xs), .xact_remote_o(xr), .cc_busy_o(busy));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic summarize;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_i);
		reg_wr <= 1'b0;
		if (a == 8'h03) mreg[0] = (d & 8'h5D) | 8'hA0;
		else if (a == 8'h04 || a == 8'h05) mreg[a - 8'h03] = d;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_i);
		reg_rd <= 1'b0;
		#1;
		check({7'h00, rvalid}, 8'h01);
		check(rdata, (a >= 8'h03 && a <= 8'h05) ? 8'(mreg[a - 8'h03]) : 8'h00);
	endtask : rd
	task automatic pulse(input int i, input int n, input logic seen);
		logic hit;
		logic idle;
		hit = 1'b0;
		idle = pin[i];
		@(posedge clk_i);
		pin[i] <= ~idle;
		repeat (n) @(posedge clk_i);
		pin[i] <= idle;
		repeat (12) begin
			@(posedge clk_i);
			#1;
			hit = hit | (pout[i] ^ idle);
		end
		check({7'h00, hit}, {7'h00, seen});
	endtask : pulse
	task automatic lat(output int c);
		c = 0;
		@(posedge clk_i);
		pin[4] <= 1'b0;
		while (pout[4] !== 1'b0) begin
			@(posedge clk_i);
			#1;
			c++;
			if (c > 30) begin
				fails++;
				summarize();
			end
		end
		@(posedge clk_i);
		pin[4] <= 1'b1;
		repeat (20) @(posedge clk_i);
	endtask : lat
	task automatic fw(input logic pa, input logic pt, input logic r);
		wr(8'h05, {pa, 7'h00});
		wr(8'h03, {4'h0, pt, 3'h0});
		@(posedge clk_i);
		go <= 1'b1;
		rem <= r;
		len <= 8'h02;
		@(posedge clk_i);
		go <= 1'b0;
		@(posedge clk_i);
		#1;
		check({7'h00, fwd}, {7'h00, pa | (pt & r)});
		repeat (8) @(posedge clk_i);
	endtask : fw
	// No abort shows as the bound of 80 being reached
	task automatic wd(input logic [6:0] n, input logic dis, input logic [7:0] l, input int lo, input int hi);
		int c;
		c = 0;
		wr(8'h04, {n, dis});
		@(posedge clk_i);
		go <= 1'b1;
		len <= l;
		@(posedge clk_i);
		go <= 1'b0;
		while (abort !== 1'b1 && c < 80) begin
			@(posedge clk_i);
			#1;
			c++;
		end
		if (c >= 80 && lo < 80) begin
			fails++;
			summarize();
		end
		check({7'h00, c >= lo && c <= hi}, 8'h01);
		repeat (220) @(posedge clk_i);
	endtask : wd
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		int c0, c1;
		logic [7:0] d;
		void'($urandom(86));
		mreg = '{8'hF0, 8'hFE, 8'h2E};
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		check({5'h00, crc, rise, aack}, 8'h04);
		for (int a = 3; a <= 6; a++) rd(8'(a));
		$display("test reset done");
		repeat (6) begin
			d = $urandom;
			wr(8'h03, d);
			#1;
			check({5'h00, crc, rise, aack}, {5'h00, mreg[0][6], mreg[0][0], mreg[0][2]});
			wr(8'h04, d | 8'h02);
			wr(8'h05, ~d);
			wr(8'h06, d);
			for (int a = 3; a <= 6; a++) rd(8'(a));
		end
		$display("test registers done");
		wr(8'h03, 8'h10);
		for (int i = 0; i < 3; i++) begin
			pulse(i, 2, 1'b0);
			pulse(i, 3, 1'b1);
		end
		wr(8'h03, 8'h00);
		pulse(0, 2, 1'b1);
		$display("test sync filter done");
		wr(8'h05, 8'h0F);
		pulse(3, 2, 1'b0);
		pulse(3, 3, 1'b1);
		wr(8'h05, 8'h09);
		pulse(3, 2, 1'b1);
		wr(8'h05, 8'h00);
		lat(c0);
		wr(8'h05, 8'h70);
		lat(c1);
		check(8'(c1 - c0), 8'h07);
		$display("test serial pins done");
		for (int k = 0; k < 8; k++) fw(k[0], k[1], k[2]);
		$display("test forwarding done");
		foreach (mreg[k]) wd(7'(k * 2 + 1), 1'b0, 8'hC8, k * 8 + 2, k * 8 + 7);
		wd(7'h03, 1'b1, 8'hC8, 80, 80);
		wd(7'h03, 1'b0, 8'h02, 80, 80);
		$display("test watchdog done");
		summarize();
	end
endmodule : tb_top
